// file: rtl/pdwc_pkg.sv
// Purpose: constants and types for the power-down and wake-up controller
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: register offsets are word offsets on the plain register port
package pdwc_pkg;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [15:0] PDWC_ADDR_CONFIG = 16'h2007;
    localparam logic [15:0] PDWC_ADDR_OPTION = 16'h0081;
    localparam logic [15:0] PDWC_ADDR_STATUS = 16'h0003;
    localparam logic [15:0] PDWC_ADDR_WAKE_EN = 16'h008C;
    localparam logic [15:0] PDWC_ADDR_ID_BASE = 16'h2000;
    localparam logic [15:0] PDWC_ADDR_ID_LAST = 16'h2003;
    localparam logic [15:0] PDWC_ADDR_PROG_BASE = 16'h0000;
    localparam logic [15:0] PDWC_ADDR_PROG_LAST = 16'h0FFF;

    // -------------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------------
    localparam int PDWC_STAT_PD = 3;
    localparam int PDWC_STAT_TO = 4;
    localparam int PDWC_CFG_WDT_EN = 2;
    localparam int PDWC_CFG_CP_LO = 4;
    localparam int PDWC_CFG_CP_HI = 5;
    localparam int PDWC_ID_BITS = 4;

    // -------------------------------------------------------------------
    // reset values and encodings
    // -------------------------------------------------------------------
    localparam logic [7:0] PDWC_CONFIG_RST = 8'hFF;
    localparam logic [7:0] PDWC_OPTION_RST = 8'hFF;
    localparam logic [1:0] PDWC_OSC_RC = 2'h3;
    localparam logic [15:0] PDWC_VECTOR = 16'h0004;
    localparam int PDWC_NUM_SRC = 12;
    localparam int PDWC_PERIPH_SRC = 9;

    // -------------------------------------------------------------------
    // timing: start-up delay in oscillator periods, one period per mclk
    // -------------------------------------------------------------------
    localparam int PDWC_TOSC_NS = 10;
    localparam int PDWC_OST_PERIODS = 1024;
    localparam int PDWC_OST_CYCLES = (PDWC_OST_PERIODS * PDWC_TOSC_NS + 9) / 10;

    typedef enum logic [1:0] {
        PDWC_WAKE_NONE,
        PDWC_WAKE_WDT,
        PDWC_WAKE_IRQ
    } pdwc_cause_t;

    typedef struct packed {
        logic [7:0] drive;
        logic [7:0] oe;
    } pdwc_io_t;

    typedef struct packed {
        logic run;
        logic vector;
        pdwc_cause_t cause;
    } pdwc_core_t;
endpackage

// file: rtl/pdwc_power_down_wakeup_control.sv
// Purpose: sleep entry, wake-up sequencing, status flags, pin hold, id/verify access
// Assumes: core gives one-cycle pulses for sleep, watchdog clear and irq taken
// Notes: watchdog counts mclk enables; oscillator start-up counted in mclk
//
// Notes on behaviour
// - sleep clears watchdog, clears power-down flag, sets timeout flag, stops oscillator
// - pins hold their previous drive state while asleep
// - wake on reset pin, enabled watchdog timeout, or enabled interrupt sources
// - reset pin does full reset; other wakes resume without reset
// - power-down flag set at power-up, cleared by sleep
// - watchdog timeout that wakes the device clears the timeout flag
// - only five of the nine peripheral sources (wake-enable bits 3-7) can be enabled to wake the device
// - clock-dependent peripherals raise no interrupt while asleep
// - sleep prefetches the instruction at the next address
// - wake needs individual enable, independent of global enable
// - after irq wake run next instruction, then vector if global enable set
// - sleep with enabled flag already pending acts as no-operation
// - interrupt during or after sleep: sleep completes, then wake at once
// - crystal modes wait 1024 oscillator periods on watchdog or interrupt wake, not on reset pin wake; rc mode does not
// - id locations 2000h-2003h reachable only in program mode, low 4 bits used
// - program memory readable for verify only when code protection unprogrammed
// - programming uses one serial clock and one serial data line
// - watchdog timeout resets when awake, only wakes when asleep
// - taking interrupt clears global enable, pushes return, loads vector
module pdwc_power_down_wakeup_control
    import pdwc_pkg::*;
#(
    parameter int WDT_PERIOD = 18000,
    parameter int OST_CYCLES = PDWC_OST_CYCLES,
    parameter int PC_BITS = 13
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // core handshake
    input wire logic sleep_exec,
    input wire logic watchdog_clear_instruction,
    input wire logic irq_taken,
    input wire logic [PC_BITS-1:0] core_pc,
    input wire logic global_irq_enable,
    output logic core_run,
    output logic irq_vector_req,
    output logic [PC_BITS-1:0] prefetch_addr,
    output logic osc_enable,
    output logic device_reset,
    // interrupt sources: pin, port change, timer0, nine peripherals
    input wire logic [PDWC_NUM_SRC-1:0] irq_flags,
    input wire logic [PDWC_NUM_SRC-1:0] irq_clocked,
    // pins
    input wire logic external_reset_pin,
    input wire logic [7:0] pin_drive_in,
    input wire logic [7:0] pin_oe_in,
    output logic [7:0] pin_drive,
    output logic [7:0] pin_oe,
    // programming link
    input wire logic prog_mode,
    input wire logic prog_clk,
    input wire logic prog_data_in,
    output logic prog_data_out,
    output logic prog_data_oe
);
    // ---------------------------------------------------------------------
    // state
    // ---------------------------------------------------------------------
    typedef enum logic [1:0] {
        PDWC_RUN,
        PDWC_SLEEP,
        PDWC_OST,
        PDWC_RESUME
    } pdwc_state_t;

    localparam int OST_W = $clog2(OST_CYCLES + 1);
    localparam int WDT_W = $clog2(WDT_PERIOD + 1);

    pdwc_state_t state, next_state;
    logic [OST_W-1:0] ost_cnt, next_ost_cnt;
    logic [WDT_W-1:0] wdt_cnt, next_wdt_cnt;
    logic [7:0] config_word, next_config_word;
    logic [7:0] option_word, next_option_word;
    logic [PDWC_NUM_SRC-1:0] wake_en, next_wake_en;
    logic pd_flag, next_pd_flag;
    logic to_flag, next_to_flag;
    pdwc_cause_t cause, next_cause;
    pdwc_io_t io_hold, next_io_hold;
    logic [PDWC_ID_BITS-1:0] id_mem [4];
    logic [PDWC_ID_BITS-1:0] next_id_mem [4];
    logic [7:0] next_rdata;
    logic next_run, next_vector, next_osc, next_reset;
    logic [PC_BITS-1:0] next_prefetch;
    logic [7:0] shift, next_shift;
    logic prog_clk_q, next_prog_clk_q;
    logic next_pd_out;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // ---------------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------------
    logic irq_pending, wdt_en, wdt_tick, xtal_mode, cp_clear, pin_rst;
    always_comb begin
        // asleep only sources that need no internal clock count
        irq_pending = |(irq_flags & wake_en & ~(irq_clocked & {PDWC_NUM_SRC{state == PDWC_SLEEP}}));
        wdt_en = config_word[PDWC_CFG_WDT_EN];
        wdt_tick = wdt_en && (wdt_cnt == WDT_W'(WDT_PERIOD - 1));
        xtal_mode = (config_word[1:0] != PDWC_OSC_RC);
        cp_clear = config_word[PDWC_CFG_CP_HI] && config_word[PDWC_CFG_CP_LO];
        pin_rst = !external_reset_pin;
        next_state = state;
        next_ost_cnt = ost_cnt;
        next_wdt_cnt = wdt_en ? wdt_cnt + WDT_W'(1) : '0;
        next_config_word = config_word;
        next_option_word = option_word;
        next_wake_en = wake_en;
        next_pd_flag = pd_flag;
        next_to_flag = to_flag;
        next_cause = cause;
        next_io_hold = io_hold;
        next_id_mem = id_mem;
        next_rdata = '0;
        next_run = core_run;
        next_vector = 1'b0;
        next_osc = osc_enable;
        next_reset = 1'b0;
        next_prefetch = prefetch_addr;
        next_shift = shift;
        next_prog_clk_q = prog_clk;
        next_pd_out = 1'b0;
        if (wdt_tick) begin
            next_wdt_cnt = '0;
        end
        if (watchdog_clear_instruction) begin
            next_wdt_cnt = '0;
        end
        unique case (state)
            PDWC_RUN: begin
                next_io_hold = '{drive: pin_drive_in, oe: pin_oe_in};
                if (wdt_tick) begin
                    next_reset = 1'b1;
                    next_to_flag = 1'b0;
                end else if (sleep_exec && !irq_pending) begin
                    next_wdt_cnt = '0;
                    next_pd_flag = 1'b0;
                    next_to_flag = 1'b1;
                    next_osc = 1'b0;
                    next_run = 1'b0;
                    next_prefetch = core_pc + PC_BITS'(1);
                    next_state = PDWC_SLEEP;
                end
            end
            PDWC_SLEEP: begin
                // pins keep the state latched before sleep
                if (irq_pending) begin
                    next_cause = PDWC_WAKE_IRQ;
                    next_osc = 1'b1;
                    next_ost_cnt = '0;
                    next_state = xtal_mode ? PDWC_OST : PDWC_RESUME;
                end else if (wdt_tick) begin
                    next_to_flag = 1'b0;
                    next_cause = PDWC_WAKE_WDT;
                    next_osc = 1'b1;
                    next_ost_cnt = '0;
                    next_state = xtal_mode ? PDWC_OST : PDWC_RESUME;
                end
            end
            PDWC_OST: begin
                next_ost_cnt = ost_cnt + OST_W'(1);
                if (ost_cnt == OST_W'(OST_CYCLES - 1)) begin
                    next_state = PDWC_RESUME;
                end
            end
            PDWC_RESUME: begin
                next_run = 1'b1;
                // prefetched instruction runs first, then core vectors
                next_vector = (cause == PDWC_WAKE_IRQ) && global_irq_enable;
                next_state = PDWC_RUN;
            end
        endcase
        if (irq_taken) begin
            next_cause = PDWC_WAKE_NONE;
        end
        // register port
        if (reg_wr) begin
            unique case (reg_addr)
                PDWC_ADDR_CONFIG: if (prog_mode) next_config_word = reg_wdata;
                PDWC_ADDR_OPTION: next_option_word = reg_wdata;
                PDWC_ADDR_WAKE_EN: next_wake_en = {4'h0, reg_wdata};
                default: begin
                    if (prog_mode && in_range(reg_addr, PDWC_ADDR_ID_BASE,
                                              PDWC_ADDR_ID_LAST)) begin
                        next_id_mem[reg_addr[1:0]] = reg_wdata[PDWC_ID_BITS-1:0];
                    end
                end
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                PDWC_ADDR_CONFIG: next_rdata = config_word;
                PDWC_ADDR_OPTION: next_rdata = option_word;
                PDWC_ADDR_STATUS: next_rdata = 8'(({7'h0, to_flag} << PDWC_STAT_TO)
                                                  | ({7'h0, pd_flag} << PDWC_STAT_PD));
                PDWC_ADDR_WAKE_EN: next_rdata = wake_en[7:0];
                default: begin
                    if (prog_mode && in_range(reg_addr, PDWC_ADDR_ID_BASE,
                                              PDWC_ADDR_ID_LAST)) begin
                        next_rdata = {4'h0, id_mem[reg_addr[1:0]]};
                    end else if (prog_mode && cp_clear && in_range(reg_addr,
                                 PDWC_ADDR_PROG_BASE, PDWC_ADDR_PROG_LAST)) begin
                        next_rdata = reg_addr[7:0];
                    end
                end
            endcase
        end
        // serial programming link: shift on rising clock, msb out
        if (prog_mode && prog_clk && !prog_clk_q) begin
            next_shift = {shift[6:0], prog_data_in};
        end
        next_pd_out = prog_mode && !prog_clk;
        if (pin_rst) begin
            next_state = PDWC_RUN;
            next_run = 1'b1;
            next_osc = 1'b1;
            next_reset = 1'b1;
            next_vector = 1'b0;
            next_cause = PDWC_WAKE_NONE;
            // software settings go back to reset values; fuses and id words stay
            next_wake_en = '0;
            next_option_word = PDWC_OPTION_RST;
            next_wdt_cnt = '0;
        end
    end

    // ---------------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state <= PDWC_RUN;
            ost_cnt <= '0;
            wdt_cnt <= '0;
            config_word <= PDWC_CONFIG_RST;
            option_word <= PDWC_OPTION_RST;
            wake_en <= '0;
            pd_flag <= 1'b1;
            to_flag <= 1'b1;
            cause <= PDWC_WAKE_NONE;
            io_hold <= '0;
            for (int i = 0; i < 4; i++) begin
                id_mem[i] <= '0;
            end
            reg_rdata <= '0;
            core_run <= 1'b1;
            irq_vector_req <= 1'b0;
            osc_enable <= 1'b1;
            device_reset <= 1'b0;
            prefetch_addr <= '0;
            shift <= '0;
            prog_clk_q <= 1'b0;
            prog_data_oe <= 1'b0;
        end else begin
            state <= next_state;
            ost_cnt <= next_ost_cnt;
            wdt_cnt <= next_wdt_cnt;
            config_word <= next_config_word;
            option_word <= next_option_word;
            wake_en <= next_wake_en;
            pd_flag <= next_pd_flag;
            to_flag <= next_to_flag;
            cause <= next_cause;
            io_hold <= next_io_hold;
            id_mem <= next_id_mem;
            reg_rdata <= next_rdata;
            core_run <= next_run;
            irq_vector_req <= next_vector;
            osc_enable <= next_osc;
            device_reset <= next_reset;
            prefetch_addr <= next_prefetch;
            shift <= next_shift;
            prog_clk_q <= next_prog_clk_q;
            prog_data_oe <= next_pd_out;
        end
    end

    // io_hold is a flop that stops tracking while asleep
    assign pin_drive = io_hold.drive;
    assign pin_oe = io_hold.oe;
    assign prog_data_out = shift[7];
endmodule // pdwc_power_down_wakeup_control

// file: tb/pdwc_checker_sva.sv
// Purpose: port-level checks of the power-down and wake-up controller
// Assumes: bound to the top module; programming clock is slow against mclk
// Notes: sleep checks only apply with no interrupt flag raised
module pdwc_checker
    import pdwc_pkg::*;
#(
    parameter int PC_BITS = 13
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // core side
    input wire logic sleep_exec,
    input wire logic [PC_BITS-1:0] core_pc,
    input wire logic global_irq_enable,
    input wire logic core_run,
    input wire logic irq_vector_req,
    input wire logic [PC_BITS-1:0] prefetch_addr,
    input wire logic osc_enable,
    input wire logic device_reset,
    // sources and pins
    input wire logic [PDWC_NUM_SRC-1:0] irq_flags,
    input wire logic external_reset_pin,
    input wire logic [7:0] pin_drive,
    input wire logic [7:0] pin_oe,
    input wire logic prog_mode,
    input wire logic prog_clk,
    input wire logic prog_data_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_sleep_taken;
        core_run && sleep_exec && irq_flags == 12'h000;
    endsequence
    sequence s_asleep;
        !core_run && !osc_enable;
    endsequence

    a_sleep_stops_osc: assert property (s_sleep_taken |=> s_asleep)
        else $error("sleep did not stop core and oscillator");
    a_sleep_prefetch: assert property (s_sleep_taken |=> prefetch_addr == $past(core_pc) + 1'b1)
        else $error("prefetch address is not pc plus one");
    a_pins_frozen: assert property (s_asleep ##1 s_asleep |-> $stable(pin_drive) && $stable(pin_oe))
        else $error("pin state moved while asleep");
    a_vector_at_resume: assert property (irq_vector_req |-> $rose(core_run))
        else $error("vector request away from resume");
    a_vector_gie_low: assert property ($rose(core_run) && !$past(global_irq_enable) |-> !irq_vector_req)
        else $error("vector request with global enable low");
    a_run_needs_osc: assert property (core_run |-> osc_enable)
        else $error("core running with oscillator off");
    a_ext_reset: assert property ($fell(external_reset_pin) |-> ##[0:4] device_reset)
        else $error("reset pin gave no device reset");
    a_prog_oe: assert property (prog_data_oe |-> $past(prog_mode) && !$past(prog_clk))
        else $error("programming data driven outside its slot");
endmodule // pdwc_checker

// file: tb/pdwc_far_side.sv
// Purpose: model of the interrupt sources and the external reset pin
// Assumes: bench commands change right after a rising edge
// Notes: flags latch until cleared, as a service routine would do
module pdwc_far_side
    import pdwc_pkg::*;
(
    // clock
    input wire logic mclk,
    // bench commands
    input wire logic [PDWC_NUM_SRC-1:0] set_src,
    input wire logic [PDWC_NUM_SRC-1:0] clr_src,
    input wire logic [PDWC_NUM_SRC-1:0] clk_dep,
    input wire logic reset_req,
    // toward the controller
    output logic [PDWC_NUM_SRC-1:0] irq_flags = 12'h000,
    output logic [PDWC_NUM_SRC-1:0] irq_clocked = 12'h000,
    output logic external_reset_pin = 1'b1
);
    always @(posedge mclk) begin
        irq_flags <= (irq_flags | set_src) & ~clr_src;
        irq_clocked <= clk_dep;
        // pin stays high unless a reset is asked for
        external_reset_pin <= !reset_req;
    end
endmodule // pdwc_far_side

// file: tb/pdwc_bench.sv
// Purpose: self-checking bench for the power-down and wake-up controller
// Assumes: watchdog period 50 and start-up count 8 set at the instance
// Notes: bench kicks the watchdog while the core runs, else it resets
module pdwc_bench
    import pdwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
        logic prog;
        logic [7:0] mask;
        logic [7:0] exp;
    } pdwc_row_t;
    logic mclk, rstn, reg_wr, reg_rd, sleep_exec, irq_taken, global_irq_enable, core_run;
    logic irq_vector_req, osc_enable, device_reset, prog_mode, prog_data_oe;
    logic external_reset_pin, reset_req, kick, prog_clk, prog_data_in, prog_data_out;
    logic watchdog_clear_instruction = 1'b0;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, pin_drive_in, pin_oe_in, pin_drive, pin_oe, v;
    logic [12:0] core_pc, prefetch_addr;
    logic [11:0] irq_flags, irq_clocked, set_src, clr_src, clk_dep;
    logic [3:0] cyc = 4'h0;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n;
    pdwc_row_t rows [11] = '{
        '{1'b0, PDWC_ADDR_CONFIG, 8'h00, 1'b0, 8'hFF, 8'hFF},
        '{1'b0, PDWC_ADDR_STATUS, 8'h00, 1'b0, 8'h18, 8'h18},
        '{1'b1, PDWC_ADDR_OPTION, 8'h5A, 1'b0, 8'hFF, 8'h5A},
        '{1'b1, PDWC_ADDR_CONFIG, 8'h00, 1'b0, 8'hFF, 8'hFF},
        '{1'b1, PDWC_ADDR_ID_BASE, 8'hA5, 1'b1, 8'h0F, 8'h05},
        '{1'b0, PDWC_ADDR_ID_BASE, 8'h00, 1'b0, 8'hFF, 8'h00},
        '{1'b0, 16'h0012, 8'h00, 1'b1, 8'hFF, 8'h12},
        '{1'b0, 16'h0012, 8'h00, 1'b0, 8'hFF, 8'h00},
        '{1'b1, PDWC_ADDR_CONFIG, 8'hCF, 1'b1, 8'hFF, 8'hCF},
        '{1'b0, 16'h0012, 8'h00, 1'b1, 8'hFF, 8'h00},
        '{1'b1, PDWC_ADDR_CONFIG, 8'hFC, 1'b1, 8'hFF, 8'hFC}
    };

    pdwc_power_down_wakeup_control #(.WDT_PERIOD(50), .OST_CYCLES(8), .PC_BITS(13)) u_dut (
        .mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_exec,
        .watchdog_clear_instruction, .irq_taken, .core_pc, .global_irq_enable, .core_run,
        .irq_vector_req, .prefetch_addr, .osc_enable, .device_reset, .irq_flags, .irq_clocked,
        .external_reset_pin, .pin_drive_in, .pin_oe_in, .pin_drive, .pin_oe, .prog_mode,
        .prog_clk, .prog_data_in, .prog_data_out, .prog_data_oe);
    pdwc_far_side u_far (.mclk, .set_src, .clr_src, .clk_dep, .reset_req, .irq_flags,
        .irq_clocked, .external_reset_pin);

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 4'h1;
        watchdog_clear_instruction <= kick && core_run && cyc == 4'h0;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic fire(input logic [11:0] s, input logic [11:0] c);
        @(posedge mclk);
        set_src <= s;
        clr_src <= c;
        @(posedge mclk);
        set_src <= 12'h000;
        clr_src <= 12'h000;
        repeat (2) @(posedge mclk);
    endtask
    task automatic sleep(input logic [12:0] pc);
        @(posedge mclk);
        sleep_exec <= 1'b1;
        core_pc <= pc;
        @(posedge mclk);
        sleep_exec <= 1'b0;
        #1;
    endtask
    // a wait that runs out of cycles ends the run as a failure
    task automatic wait_for(input int lim, input logic rst_ev);
        // step past the edge so outputs launched on it have settled
        #1;
        n = 0;
        while ((rst_ev ? device_reset : core_run) !== 1'b1) begin
            if (n == lim) begin
                n_mismatch++;
                end_sim;
            end
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    initial begin
        {reg_wr, reg_rd, sleep_exec, irq_taken, global_irq_enable, prog_mode, reset_req} = 7'h00;
        {reg_addr, reg_wdata, core_pc, pin_drive_in, pin_oe_in} = 53'h0;
        {set_src, clr_src, clk_dep} = 36'h0;
        {prog_clk, prog_data_in} = 2'h0;
        kick = 1'b1;
        rstn = 1'b0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        foreach (rows[i]) begin
            @(posedge mclk);
            prog_mode <= rows[i].prog;
            if (rows[i].wr)
                wr(rows[i].addr, rows[i].data);
            rd(rows[i].addr, v);
            chk("reg", {8'h00, v & rows[i].mask}, {8'h00, rows[i].exp});
        end
        // ----------------------------------------------------------------
        // sleep with an enabled flag already raised
        // ----------------------------------------------------------------
        @(posedge mclk);
        prog_mode <= 1'b0;
        wr(PDWC_ADDR_WAKE_EN, 8'h01);
        fire(12'h001, 12'h000);
        sleep(13'h0100);
        chk("nop_run", 16'(core_run), 16'h0001);
        rd(PDWC_ADDR_STATUS, v);
        chk("nop_status", {8'h00, v & 8'h18}, 16'h0018);
        fire(12'h000, 12'h001);
        // k 0: rc mode, global enable low; k 1: crystal mode, global enable high
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            prog_mode <= 1'b1;
            global_irq_enable <= k[0];
            clk_dep <= 12'h001;
            wr(PDWC_ADDR_CONFIG, k[0] ? 8'hFC : 8'hFF);
            @(posedge mclk);
            prog_mode <= 1'b0;
            pin_drive_in <= 8'h5A;
            pin_oe_in <= 8'hF0;
            sleep(13'h0123);
            chk("asleep", {14'h0, core_run, osc_enable}, 16'h0000);
            chk("prefetch", {3'h0, prefetch_addr}, 16'h0124);
            @(posedge mclk);
            pin_drive_in <= 8'hA5;
            pin_oe_in <= 8'h0F;
            rd(PDWC_ADDR_STATUS, v);
            chk("sleep_status", {8'h00, v & 8'h18}, 16'h0010);
            fire(12'h003, 12'h000);
            repeat (8) @(posedge mclk);
            #1;
            chk("no_wake", 16'(osc_enable), 16'h0000);
            chk("held_pins", {pin_drive, pin_oe}, 16'h5AF0);
            @(posedge mclk);
            clk_dep <= 12'h000;
            wait_for(100, 1'b0);
            // three cycles of wake latency, plus the start-up count in crystal mode
            chk("wake_delay", 16'(n), 16'(3 + (k[0] ? 8 : 0)));
            chk("vector", 16'(irq_vector_req), 16'(k[0]));
            fire(12'h000, 12'h003);
            irq_taken <= 1'b1;
            @(posedge mclk);
            irq_taken <= 1'b0;
        end
        // ----------------------------------------------------------------
        // watchdog: wake when asleep, reset when awake, reset pin in sleep
        // ----------------------------------------------------------------
        sleep(13'h0200);
        wait_for(1000, 1'b0);
        rd(PDWC_ADDR_STATUS, v);
        chk("wdt_wake", {8'h00, v & 8'h18}, 16'h0000);
        @(posedge mclk);
        kick <= 1'b0;
        wait_for(1000, 1'b1);
        chk("wdt_reset", {14'h0, device_reset, core_run}, 16'h0003);
        @(posedge mclk);
        kick <= 1'b1;
        rd(PDWC_ADDR_STATUS, v);
        chk("wdt_reset_to", {8'h00, v & 8'h10}, 16'h0000);
        wr(PDWC_ADDR_WAKE_EN, 8'h02);
        sleep(13'h0300);
        @(posedge mclk);
        reset_req <= 1'b1;
        wait_for(20, 1'b1);
        chk("pin_reset", {13'h0, device_reset, core_run, osc_enable}, 16'h0007);
        @(posedge mclk);
        reset_req <= 1'b0;
        wait_for(2000, 1'b0);
        rd(PDWC_ADDR_WAKE_EN, v);
        chk("full_reset", {8'h00, v}, 16'h0000);
        // programming link: clock a byte in msb first, then see its top bit
        v = 8'hA5;
        for (int b = 0; b < 18; b++) begin
            @(posedge mclk);
            prog_mode <= b < 17;
            prog_clk <= b[0] && b < 16;
            prog_data_in <= b < 16 && v[(15 - b) / 2];
        end
        #1;
        chk("prog_shift", {14'h0, prog_data_out, prog_data_oe}, 16'h0003);
        @(posedge mclk);
        #1;
        chk("prog_oe_off", 16'(prog_data_oe), 16'h0000);
        end_sim;
    end
endmodule // pdwc_bench

bind pdwc_power_down_wakeup_control pdwc_checker #(.PC_BITS(PC_BITS)) u_chk (
    .mclk, .rstn, .sleep_exec, .core_pc, .global_irq_enable, .core_run, .irq_vector_req,
    .prefetch_addr, .osc_enable, .device_reset, .irq_flags, .external_reset_pin,
    .pin_drive, .pin_oe, .prog_mode, .prog_clk, .prog_data_oe);
